//--- design/rcs_consts.svh
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// Clock and printed minimum times, in ns
`define RCS_CLK_NS      50
`define RCS_SUPPLY_NS   40000
`define RCS_SETTLE_NS   200000
`define RCS_GAP_NS      250
`define RCS_PULSE_NS    60
`define RCS_LEAD_NS     100
// Least time to whole cycles, never below one
`define RCS_CYC(ns)     ((((ns) + `RCS_CLK_NS - 1) / `RCS_CLK_NS) < 1 ? 1 : \
                         (((ns) + `RCS_CLK_NS - 1) / `RCS_CLK_NS))

// Programming word
`define RCS_SHORT_LEN   16
`define RCS_LONG_LEN    25
`define RCS_RECOV_TAG   9'h140
`define RCS_REF_HALF    2
`define RCS_RECOV_TICKS 1

// Register byte offsets
`define RCS_ADDR_CTRL   8'h00
`define RCS_ADDR_WORD   8'h04
`define RCS_ADDR_CMD    8'h08
`define RCS_ADDR_STAT   8'h0c
`define RCS_ADDR_RXD    8'h10

// Control register fields
`define RCS_CTRL_PWR    0
`define RCS_CTRL_RX     1
`define RCS_CTRL_TX     2
`define RCS_CTRL_TXV    3
`define RCS_CTRL_TXBIT  4
`define RCS_CTRL_W      5
`define RCS_CTRL_RST    5'h00
`define RCS_WORD_RST    25'h0000000

// Command register fields
`define RCS_CMD_GO      0
`define RCS_CMD_LONG    1

// Status register fields
`define RCS_ST_READY    0
`define RCS_ST_BUSY     1
`define RCS_ST_SETTLED  2
`define RCS_ST_TXON     3
`define RCS_ST_RXON     4
`define RCS_ST_RXBIT    5
`define RCS_ST_PEND     6

`endif

//--- design/rcs_pkg.sv
package rcs_pkg;
  typedef enum logic [5:0] {
    RCS_OFF    = 6'h01,
    RCS_SUPPLY = 6'h02,
    RCS_IDLE   = 6'h04,
    RCS_LEAD   = 6'h08,
    RCS_SHIFT  = 6'h10,
    RCS_GAP    = 6'h20
  } rcs_ctl_state_t;
endpackage

//--- design/rcs_link_if.sv
`timescale 1ns/1ps
interface rcs_link_if;
  logic aux_regulator_power_up;
  logic transceiver_power_up;
  logic prog_clock;
  logic prog_data;
  logic prog_enable_n;
  logic ref_clock;
  logic rx_path_on;
  logic tx_path_on;
  logic open_loop_disable_n;
  logic tx_data;
  logic rx_data;
  logic rx_clock;

  modport device (
    input  aux_regulator_power_up, transceiver_power_up, prog_clock, prog_data,
    input  prog_enable_n, ref_clock, rx_path_on, tx_path_on, open_loop_disable_n,
    input  tx_data,
    output rx_data, rx_clock
  );
  modport controller (
    output aux_regulator_power_up, transceiver_power_up, prog_clock, prog_data,
    output prog_enable_n, ref_clock, rx_path_on, tx_path_on, open_loop_disable_n,
    output tx_data,
    input  rx_data, rx_clock
  );
endinterface

//--- design/rcs_device.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_device
  import rcs_pkg::*;
#(
  parameter int RECOV_TICKS = `RCS_RECOV_TICKS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  rcs_link_if.device       link,
  input  wire logic        demod_bit,
  output logic             regulator_enable,
  output logic             synth_enable,
  output logic             rx_path_enable,
  output logic             tx_path_enable,
  output logic             ramp_start,
  output logic             open_loop_mod,
  output logic             tx_sample,
  output logic             tx_sample_valid,
  output logic [24:0]      active_config,
  output logic             config_latched,
  output logic             recovery_enable
);
  if (RECOV_TICKS < 1 || RECOV_TICKS > 255) begin : g_chk
    $error("RECOV_TICKS must be 1 to 255");
  end

  // Two-flop synchronisers on every link input
  logic [9:0] meta_reg;
  logic [9:0] sync_reg;
  logic [9:0] prev_reg;
  wire  [9:0] raw_in = {link.aux_regulator_power_up, link.transceiver_power_up,
                        link.prog_clock, link.prog_data, link.prog_enable_n,
                        link.ref_clock, link.rx_path_on, link.tx_path_on,
                        link.open_loop_disable_n, link.tx_data};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 10'h000;
      sync_reg <= 10'h000;
      prev_reg <= 10'h000;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  wire s_aux_regulator_power_up  = sync_reg[9];
  wire s_transceiver_power_up  = sync_reg[8];
  wire s_sclk    = sync_reg[7];
  wire s_sdata   = sync_reg[6];
  wire s_sen_n   = sync_reg[5];
  wire s_ref     = sync_reg[4];
  wire s_rx_on   = sync_reg[3];
  wire s_tx_on   = sync_reg[2];
  wire s_ole_n   = sync_reg[1];
  wire s_txd     = sync_reg[0];
  wire powered   = s_aux_regulator_power_up & s_transceiver_power_up;
  wire sclk_rise = s_sclk & ~prev_reg[7] & ~s_sen_n & powered;
  wire sen_fall  = ~s_sen_n & prev_reg[5];
  wire sen_rise  = s_sen_n & ~prev_reg[5] & powered;
  wire ref_tick  = s_ref & ~prev_reg[4] & powered;
  wire tx_rise   = s_tx_on & ~prev_reg[2] & powered;
  wire rx_act    = s_rx_on & powered;
  wire tx_act    = s_tx_on & powered;

  // Serial shifter; surplus leading bits fall off the top
  logic [24:0] shift_reg;
  logic [4:0]  count_reg;
  wire  long_word = count_reg >= 5'(`RCS_LONG_LEN);
  wire  [24:0] latch_word = long_word ? shift_reg :
                            {9'h000, shift_reg[`RCS_SHORT_LEN-1:0]};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= 25'h0000000;
      count_reg <= 5'h00;
    end else if (sen_fall) begin
      count_reg <= 5'h00;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[23:0], s_sdata};
      if (!long_word) count_reg <= count_reg + 5'h01;
    end
  end

  // Latched configuration and settling start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_config   <= `RCS_WORD_RST;
      config_latched  <= 1'b0;
      recovery_enable <= 1'b0;
    end else begin
      config_latched <= sen_rise;
      if (sen_rise) begin
        active_config   <= latch_word;
        recovery_enable <= long_word && (latch_word[24:16] == `RCS_RECOV_TAG);
      end
    end
  end

  // Enables follow the power and path inputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regulator_enable <= 1'b0;
      synth_enable     <= 1'b0;
      rx_path_enable   <= 1'b0;
      tx_path_enable   <= 1'b0;
      ramp_start       <= 1'b0;
      open_loop_mod    <= 1'b0;
    end else begin
      regulator_enable <= s_aux_regulator_power_up;
      synth_enable     <= s_transceiver_power_up;
      rx_path_enable   <= rx_act;
      tx_path_enable   <= tx_act;
      ramp_start       <= tx_rise;
      open_loop_mod    <= tx_act & ~s_ole_n;
    end
  end

  // Transmit data sampled on reference edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sample       <= 1'b0;
      tx_sample_valid <= 1'b0;
    end else begin
      tx_sample_valid <= ref_tick & tx_act;
      if (ref_tick && tx_act) tx_sample <= s_txd;
    end
  end

  // Receive outputs; data moves on the rising recovered clock so the
  // falling edge finds it stable
  logic [7:0] recov_cnt_reg;
  logic       rx_clock_reg;
  logic       rx_data_reg;
  wire        recov_step = ref_tick & rx_act &
                           (recov_cnt_reg == 8'(RECOV_TICKS - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      recov_cnt_reg <= 8'h00;
      rx_clock_reg  <= 1'b0;
      rx_data_reg   <= 1'b0;
    end else if (!rx_act) begin
      recov_cnt_reg <= 8'h00;
      rx_clock_reg  <= 1'b0;
    end else if (ref_tick) begin
      recov_cnt_reg <= recov_step ? 8'h00 : recov_cnt_reg + 8'h01;
      if (!recovery_enable) begin
        rx_data_reg <= demod_bit;
      end else if (recov_step) begin
        rx_clock_reg <= ~rx_clock_reg;
        if (!rx_clock_reg) rx_data_reg <= demod_bit;
      end
    end
  end

  assign link.rx_clock = rx_clock_reg;
  assign link.rx_data  = rx_data_reg;
endmodule

//--- design/rcs_controller.sv
// Operation
// - Raise both power-up inputs to leave power-down
// - Transceiver power-up enables synthesizer, PLL, VCO
// - Wait 40 us for supplies before programming
// - Enable rising latches word, starts PLL settling
// - Wait 200 us settling after latching enable
// - Reference clock runs whenever PLL operates
// - Device timing derives from the reference clock
// - Program channel, deviation trim, or recovery bits
// - Receive slot presents data and recovered clock
// - Drive open-loop disable low when applying data
// - Send 1-0-1-0 preamble from transmit enable
// - Leave 250 ns between programming transactions
// - Shift on rising clock, MSB first, extras dropped
// - Word is 16 bits, or 25 with recovery
// - Path enables activate receive or transmit circuits
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rcs_consts.svh"
module rcs_controller
  import rcs_pkg::*;
#(
  parameter int SUPPLY_CYC = `RCS_CYC(`RCS_SUPPLY_NS),
  parameter int SETTLE_CYC = `RCS_CYC(`RCS_SETTLE_NS),
  parameter int GAP_CYC    = `RCS_CYC(`RCS_GAP_NS),
  parameter int HALF_CYC   = `RCS_CYC(`RCS_PULSE_NS),
  parameter int LEAD_CYC   = `RCS_CYC(`RCS_LEAD_NS),
  parameter int REF_HALF   = `RCS_REF_HALF
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_wdata,
  output logic      [31:0] wb_rdata,
  output logic             wb_ack,
  rcs_link_if.controller   link
);
  if (SUPPLY_CYC < 1 || SUPPLY_CYC > 65535 || SETTLE_CYC < 1 || SETTLE_CYC > 65535 ||
      GAP_CYC < 1 || GAP_CYC > 65535 || HALF_CYC < 1 || HALF_CYC > 65535 ||
      LEAD_CYC < 1 || LEAD_CYC > 65535 || REF_HALF < 2 || REF_HALF > 255) begin : g_chk
    $error("rcs_controller timing parameter out of range");
  end

  // Wishbone decode; request seen on one edge, writes land on the acked edge
  wire wb_hit  = wb_cyc & wb_stb & ~wb_ack;
  wire wr_hit  = wb_cyc & wb_stb & wb_ack & wb_we;
  wire wr_ctrl = wr_hit & wb_sel[0] & (wb_adr == `RCS_ADDR_CTRL);
  wire wr_word = wr_hit & (wb_adr == `RCS_ADDR_WORD);
  wire wr_cmd  = wr_hit & wb_sel[0] & (wb_adr == `RCS_ADDR_CMD);
  wire go_req  = wr_cmd & wb_wdata[`RCS_CMD_GO];

  logic [`RCS_CTRL_W-1:0] ctrl_reg;
  logic [24:0]            word_reg;
  logic                   long_reg;
  logic                   pend_reg;
  logic [7:0]             rx_shift_reg;

  rcs_ctl_state_t state_reg;
  rcs_ctl_state_t state_next;
  logic [15:0]    timer_reg;
  logic [15:0]    timer_next;
  logic [4:0]     bit_reg;
  logic [4:0]     bit_next;
  logic           sclk_reg;
  logic           sclk_next;
  logic           sdata_reg;
  logic           sdata_next;
  logic           sen_n_reg;
  logic           sen_n_next;
  logic           latch_next;
  logic [15:0]    settle_reg;
  logic           programmed_reg;

  wire pwr      = ctrl_reg[`RCS_CTRL_PWR];
  wire settled  = programmed_reg & (settle_reg == 16'h0000);
  wire slot_ok  = (state_reg == RCS_IDLE) & settled;
  wire take_go  = (state_reg == RCS_IDLE) & pend_reg;
  wire [4:0] last_bit = long_reg ? 5'(`RCS_LONG_LEN - 1) : 5'(`RCS_SHORT_LEN - 1);

  // Register writes; a fresh request beats the clear on take
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `RCS_CTRL_RST;
      word_reg <= `RCS_WORD_RST;
      long_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= wb_wdata[`RCS_CTRL_W-1:0];
      if (wr_word && wb_sel[0]) word_reg[7:0]   <= wb_wdata[7:0];
      if (wr_word && wb_sel[1]) word_reg[15:8]  <= wb_wdata[15:8];
      if (wr_word && wb_sel[2]) word_reg[23:16] <= wb_wdata[23:16];
      if (wr_word && wb_sel[3]) word_reg[24]    <= wb_wdata[24];
      if (go_req) begin
        pend_reg <= 1'b1;
        long_reg <= wb_wdata[`RCS_CMD_LONG];
      end else if (take_go || !pwr) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Read mux and single-cycle-late acknowledge
  wire [31:0] st_word = {25'h0000000, pend_reg, rx_shift_reg[0],
                         link.rx_path_on, link.tx_path_on, settled,
                         ~(state_reg == RCS_IDLE) & ~(state_reg == RCS_OFF),
                         (state_reg == RCS_IDLE)};
  wire [31:0] rd_mux  = (wb_adr == `RCS_ADDR_CTRL) ? {27'h0000000, ctrl_reg} :
                        (wb_adr == `RCS_ADDR_WORD) ? {7'h00, word_reg} :
                        (wb_adr == `RCS_ADDR_CMD)  ? {30'h00000000, long_reg, pend_reg} :
                        (wb_adr == `RCS_ADDR_STAT) ? st_word :
                        (wb_adr == `RCS_ADDR_RXD)  ? {24'h000000, rx_shift_reg} :
                        32'h00000000;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack   <= 1'b0;
      wb_rdata <= 32'h00000000;
    end else begin
      wb_ack <= wb_hit;
      if (wb_hit && !wb_we) wb_rdata <= rd_mux;
    end
  end

  // Sequencer: supply wait, serial word, inter-transaction gap
  always_comb begin
    state_next = state_reg;
    timer_next = (timer_reg != 16'h0000) ? timer_reg - 16'h0001 : timer_reg;
    bit_next   = bit_reg;
    sclk_next  = sclk_reg;
    sdata_next = sdata_reg;
    sen_n_next = sen_n_reg;
    latch_next = 1'b0;
    if (!pwr && state_reg != RCS_OFF) begin
      state_next = RCS_OFF;
      sen_n_next = 1'b1;
      sclk_next  = 1'b0;
    end else begin
      case (state_reg)
        RCS_OFF: begin
          if (pwr) begin
            state_next = RCS_SUPPLY;
            timer_next = 16'(SUPPLY_CYC - 1);
          end
        end
        RCS_SUPPLY: begin
          if (timer_reg == 16'h0000) state_next = RCS_IDLE;
        end
        RCS_IDLE: begin
          if (pend_reg) begin
            state_next = RCS_LEAD;
            sen_n_next = 1'b0;
            bit_next   = last_bit;
            sdata_next = word_reg[last_bit];
            timer_next = 16'(LEAD_CYC - 1);
          end
        end
        RCS_LEAD: begin
          if (timer_reg == 16'h0000) begin
            state_next = RCS_SHIFT;
            timer_next = 16'(HALF_CYC - 1);
          end
        end
        RCS_SHIFT: begin
          if (timer_reg == 16'h0000) begin
            timer_next = 16'(HALF_CYC - 1);
            if (!sclk_reg) begin
              sclk_next = 1'b1;
            end else begin
              sclk_next = 1'b0;
              if (bit_reg == 5'h00) begin
                sen_n_next = 1'b1;
                latch_next = 1'b1;
                state_next = RCS_GAP;
                timer_next = 16'(GAP_CYC - 1);
              end else begin
                bit_next   = bit_reg - 5'h01;
                sdata_next = word_reg[bit_reg - 5'h01];
              end
            end
          end
        end
        RCS_GAP: begin
          if (timer_reg == 16'h0000) state_next = RCS_IDLE;
        end
        default: state_next = RCS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= RCS_OFF;
      timer_reg <= 16'h0000;
      bit_reg   <= 5'h00;
      sclk_reg  <= 1'b0;
      sdata_reg <= 1'b0;
      sen_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      bit_reg   <= bit_next;
      sclk_reg  <= sclk_next;
      sdata_reg <= sdata_next;
      sen_n_reg <= sen_n_next;
    end
  end

  // Settling countdown from each latching enable edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_reg     <= 16'h0000;
      programmed_reg <= 1'b0;
    end else if (state_reg == RCS_OFF) begin
      settle_reg     <= 16'h0000;
      programmed_reg <= 1'b0;
    end else if (latch_next) begin
      settle_reg     <= 16'(SETTLE_CYC);
      programmed_reg <= 1'b1;
    end else if (settle_reg != 16'h0000) begin
      settle_reg <= settle_reg - 16'h0001;
    end
  end

  // Reference clock divider; runs in every powered state
  logic [7:0] ref_div_reg;
  logic       ref_clk_reg;
  wire        ref_edge = (ref_div_reg == 8'(REF_HALF - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_div_reg <= 8'h00;
      ref_clk_reg <= 1'b0;
    end else if (state_reg == RCS_OFF) begin
      ref_div_reg <= 8'h00;
      ref_clk_reg <= 1'b0;
    end else begin
      ref_div_reg <= ref_edge ? 8'h00 : ref_div_reg + 8'h01;
      if (ref_edge) ref_clk_reg <= ~ref_clk_reg;
    end
  end

  // Path enables and transmit data; preamble until real data flows
  logic rx_on_reg;
  logic tx_on_reg;
  logic txd_reg;
  logic ole_n_reg;
  wire  want_tx = ctrl_reg[`RCS_CTRL_TX] & ~ctrl_reg[`RCS_CTRL_RX] & slot_ok;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_on_reg <= 1'b0;
      tx_on_reg <= 1'b0;
      txd_reg   <= 1'b1;
      ole_n_reg <= 1'b1;
    end else begin
      rx_on_reg <= ctrl_reg[`RCS_CTRL_RX] & slot_ok;
      tx_on_reg <= want_tx;
      // Open loop ends on the same edge as the slot, never a cycle later
      ole_n_reg <= ~(want_tx & tx_on_reg & ctrl_reg[`RCS_CTRL_TXV]);
      if (!tx_on_reg) begin
        txd_reg <= 1'b1;
      end else if (ctrl_reg[`RCS_CTRL_TXV]) begin
        txd_reg <= ctrl_reg[`RCS_CTRL_TXBIT];
      end else if (ref_edge && ref_clk_reg) begin
        txd_reg <= ~txd_reg;
      end
    end
  end

  // Receive capture on the falling recovered clock
  logic [1:0] rx_meta_reg;
  logic [1:0] rx_sync_reg;
  logic       rx_clk_prev_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_meta_reg     <= 2'h0;
      rx_sync_reg     <= 2'h0;
      rx_clk_prev_reg <= 1'b0;
      rx_shift_reg    <= 8'h00;
    end else begin
      rx_meta_reg     <= {link.rx_clock, link.rx_data};
      rx_sync_reg     <= rx_meta_reg;
      rx_clk_prev_reg <= rx_sync_reg[1];
      if (rx_on_reg && rx_clk_prev_reg && !rx_sync_reg[1])
        rx_shift_reg <= {rx_shift_reg[6:0], rx_sync_reg[0]};
    end
  end

  // Power inputs rise and fall together
  assign link.aux_regulator_power_up = (state_reg != RCS_OFF);
  assign link.transceiver_power_up   = (state_reg != RCS_OFF);
  assign link.prog_clock             = sclk_reg;
  assign link.prog_data              = sdata_reg;
  assign link.prog_enable_n          = sen_n_reg;
  assign link.ref_clock              = ref_clk_reg;
  assign link.rx_path_on             = rx_on_reg;
  assign link.tx_path_on             = tx_on_reg;
  assign link.open_loop_disable_n    = ole_n_reg;
  assign link.tx_data                = txd_reg;
endmodule

//--- dv/rcs_link_chk.sv
`timescale 1ns/1ps
module rcs_link_chk #(
  parameter int SUPPLY_CYC = 800,
  parameter int SETTLE_CYC = 4000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic aux_regulator_power_up,
  input wire logic transceiver_power_up,
  input wire logic prog_clock,
  input wire logic prog_data,
  input wire logic prog_enable_n,
  input wire logic ref_clock,
  input wire logic rx_path_on,
  input wire logic tx_path_on,
  input wire logic open_loop_disable_n,
  input wire logic tx_data,
  input wire logic rx_data,
  input wire logic rx_clock
);
  logic [15:0] pwr_cnt_reg;
  logic [15:0] settle_cnt_reg;
  logic [3:0]  stall_reg;
  logic        ref_reg;
  // Ages since power-up, latch and ref edge; saturate so they never wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_cnt_reg    <= 16'h0;
      settle_cnt_reg <= 16'h0;
      stall_reg      <= 4'h0;
      ref_reg        <= 1'b0;
    end else begin
      pwr_cnt_reg    <= !transceiver_power_up ? 16'h0 : pwr_cnt_reg + {15'h0, ~&pwr_cnt_reg};
      settle_cnt_reg <= !prog_enable_n ? 16'h0 : settle_cnt_reg + {15'h0, ~&settle_cnt_reg};
      stall_reg      <= (ref_clock != ref_reg) ? 4'h0 : stall_reg + {3'h0, ~&stall_reg};
      ref_reg        <= ref_clock;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  pwr_pair_a: assert property (aux_regulator_power_up == transceiver_power_up)
    else $error("power-up pins differ");
  supply_wait_a: assert property ($fell(prog_enable_n) |->
    pwr_cnt_reg >= 16'(SUPPLY_CYC))
    else $error("programming before supply wait");
  prog_power_a: assert property (!prog_enable_n |-> transceiver_power_up)
    else $error("programming while powered down");
  gap_hold_a: assert property ($rose(prog_enable_n) |-> prog_enable_n [*5])
    else $error("transaction gap too short");
  shift_frame_a: assert property ($rose(prog_clock) |->
    !prog_enable_n && $stable(prog_data))
    else $error("serial clock outside frame or data moved");
  settle_wait_a: assert property ($rose(rx_path_on || tx_path_on) |->
    settle_cnt_reg >= 16'(SETTLE_CYC))
    else $error("slot before settling");
  ref_live_a: assert property ((!prog_enable_n || rx_path_on || tx_path_on) |->
    stall_reg < 4'h8)
    else $error("reference clock stopped");
  ole_slot_a: assert property (!open_loop_disable_n |-> tx_path_on && !rx_path_on)
    else $error("open loop outside transmit slot");
  preamble_a: assert property ($rose(tx_path_on) |-> tx_data ##[1:8] !tx_data)
    else $error("no preamble at slot start");
endmodule

//--- dv/test_radio_control_sequencer.sv
`timescale 1ns/1ps
`include "rcs_consts.svh"
module test_radio_control_sequencer;
  logic        clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, demod_bit;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdata, wb_rdata, q;
  logic        regulator_enable, synth_enable, rx_path_enable, tx_path_enable, ramp_start;
  logic        open_loop_mod, tx_sample, tx_sample_valid, config_latched, recovery_enable;
  logic [24:0] active_config, sh, last_word;
  logic        tx_q, rx_q, ramp_seen;
  int          error_cnt, checked, n, nbits, last_n, latches, txc, rxc, tsv;
  rcs_link_if link ();
  rcs_controller #(.SUPPLY_CYC(20), .SETTLE_CYC(50)) rcs_controller_inst (.clk, .reset_n,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_wdata, .wb_rdata, .wb_ack, .link(link));
  rcs_device rcs_device_inst (.clk, .reset_n, .link(link), .demod_bit, .regulator_enable,
    .synth_enable, .rx_path_enable, .tx_path_enable, .ramp_start, .open_loop_mod, .tx_sample,
    .tx_sample_valid, .active_config, .config_latched, .recovery_enable);
  rcs_link_chk #(.SUPPLY_CYC(20), .SETTLE_CYC(50)) rcs_link_chk_inst (.clk, .reset_n,
    .aux_regulator_power_up(link.aux_regulator_power_up),
    .transceiver_power_up(link.transceiver_power_up), .prog_clock(link.prog_clock),
    .prog_data(link.prog_data), .prog_enable_n(link.prog_enable_n),
    .ref_clock(link.ref_clock), .rx_path_on(link.rx_path_on), .tx_path_on(link.tx_path_on),
    .open_loop_disable_n(link.open_loop_disable_n), .tx_data(link.tx_data),
    .rx_data(link.rx_data), .rx_clock(link.rx_clock));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Wire-side capture of each serial word, independent of the device
  always @(posedge link.prog_clock) if (!link.prog_enable_n) begin
    sh = {sh[23:0], link.prog_data};
    nbits++;
  end
  always @(posedge link.prog_enable_n) begin
    last_word = sh;
    last_n = nbits;
    sh = 25'h0;
    nbits = 0;
  end
  // Event counters for pulses and toggling lines
  always @(posedge clk) begin
    tx_q <= link.tx_data;
    rx_q <= link.rx_clock;
    if (config_latched === 1'b1) latches++;
    if (tx_sample_valid === 1'b1) tsv++;
    if (ramp_start === 1'b1) ramp_seen <= 1'b1;
    if (link.tx_path_on === 1'b1 && link.tx_data !== tx_q) txc++;
    if (link.rx_clock !== rx_q) rxc++;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle; waits for ack, bench timeout bounds it
  task automatic wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdata <= d;
    do @(posedge clk);
    while (wb_ack !== 1'b1);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_cnt(input int k);
    for (n = 0; n < 500 && latches < k; n++) @(posedge clk);
  endtask
  task automatic poll_stat(input int b);
    for (n = 0; n < 200 && q[b] !== 1'b1; n++) wb_rw(1'b0, `RCS_ADDR_STAT, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop;
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, demod_bit, ramp_seen} = 5'h0;
    {wb_adr, wb_sel, wb_wdata, sh} = 0;
    {error_cnt, checked, nbits, latches, txc, rxc, tsv} = 0;
    wb_sel = 4'hf;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wb_rw(1'b0, `RCS_ADDR_STAT, 32'h0);
    check("status", 32'h0, q);
    // Go while powered off is dropped
    wb_rw(1'b1, `RCS_ADDR_CMD, 32'h1);
    repeat (10) @(posedge clk);
    check("enable off", 32'h1, link.prog_enable_n);
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    check("pins", 32'h3, {link.aux_regulator_power_up, link.transceiver_power_up});
    check("synth", 32'h3, {regulator_enable, synth_enable});
    poll_stat(0);
    check("ready", 32'h1, q[0]);
    wb_rw(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h0, q);
    wb_rw(1'b1, `RCS_ADDR_WORD, 32'h6b35);
    wb_rw(1'b1, `RCS_ADDR_CMD, 32'h1);
    wait_cnt(1);
    check("config", 32'h6b35, active_config);
    check("wire word", 32'h6b35, last_word);
    check("bits", 32'd16, last_n);
    // Long word, second go lands while busy and must run once more
    wb_rw(1'b1, `RCS_ADDR_WORD, 32'h1400123);
    wb_rw(1'b1, `RCS_ADDR_CMD, 32'h3);
    wb_rw(1'b1, `RCS_ADDR_CMD, 32'h3);
    wait_cnt(3);
    repeat (20) @(posedge clk);
    check("latches", 32'd3, latches);
    check("long", 32'h1400123, active_config);
    check("bits", 32'd25, last_n);
    check("recovery", 32'h1, recovery_enable);
    poll_stat(2);
    check("settled", 32'h1, q[2]);
    demod_bit <= 1'b1;
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'h3);
    // Eight falling recovered edges take about 64 cycles
    repeat (80) @(posedge clk);
    check("rx path", 32'h1, rx_path_enable);
    check("rx data", 32'h1, link.rx_data);
    check("rx clock", 32'h1, rxc > 0);
    wb_rw(1'b0, `RCS_ADDR_RXD, 32'h0);
    check("rx bits", 32'hff, q);
    demod_bit <= 1'b0;
    repeat (40) @(posedge clk);
    wb_rw(1'b0, `RCS_ADDR_STAT, 32'h0);
    check("rx stat", 32'h1, q[5:4]);
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'h5);
    repeat (40) @(posedge clk);
    check("tx path", 32'h1, {tx_path_enable, ramp_seen} == 2'b11);
    check("preamble", 32'h1, txc > 4);
    check("closed", 32'h1, link.open_loop_disable_n);
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'h1d);
    repeat (20) @(posedge clk);
    check("open", 32'h3, {open_loop_mod, link.tx_data});
    check("ole", 32'h0, link.open_loop_disable_n);
    check("sample", 32'h1, tx_sample);
    check("sample valid", 32'h1, tsv > 0);
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'hd);
    repeat (20) @(posedge clk);
    check("sample", 32'h0, tx_sample);
    wb_rw(1'b1, `RCS_ADDR_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    check("down", 32'h0, {link.aux_regulator_power_up, link.transceiver_power_up});
    check("off", 32'h0, {regulator_enable, synth_enable, tx_path_enable});
    report_and_stop;
  end
endmodule
